/* hw/drive_parameter_supervisor.sv */
/*
 Drive parameter supervisor: ramp scaling, joystick shaping, buttons, timers,
 battery display and alarms, braking rates.
 Assumes pins arrive asynchronously and parameters come from local logic.
*/
// Functional notes
// - Lowest speed setting decelerates at minimum percent of programmed deceleration.
// - Lowest setting turn acceleration is minimum percent of programmed value.
// - Lowest setting turn deceleration is minimum percent of programmed value.
// - Settings two to four interpolate linearly between lowest and full rate.
// - Full programmed rate applies only at speed setting five.
// - Sleep after 1 to 30 idle minutes; zero never sleeps.
// - Inversion on makes forward deflection drive in reverse.
// - Trim -9 to +9 offsets left and right demands for straight travel.
// - Beep loudness follows 0 to 10; zero is silent.
// - Without drive adjust, speed buttons work only when released and at rest.
// - Service due flashes five LEDs 100 ms on, 1 s off, first 20 s.
// - Low battery code selects LED pattern; codes one to five sound alarm.
// - Cut out only after voltage stays at or below threshold whole time.
// - Low voltage time programmable 1 to 255 seconds.
// - Fast brake uses its rate, or normal deceleration if that is higher.
// - Power off while moving stops at soft stop rate.
// - Stopping from reverse uses 25 to 100 percent of deceleration; the code applies soft_rev_pct as given, with no clamp.
// - Reverse alarm sounds while driving in reverse.
// - Brake disconnect alarm sounds while brakes sensed disconnected.
// - Brake fault detection only when enabled.
// - Joystick held deflected beyond 0 to 60 minutes cuts drive; zero disables.
// - Stationary timer restarts when movement exceeds the window.
module drive_parameter_supervisor
	import drive_sup_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Ramp parameters.
	input wire logic [drive_sup_pkg::RATE_W-1:0] decel_rate,
	input wire logic [drive_sup_pkg::RATE_W-1:0] turn_accel_rate,
	input wire logic [drive_sup_pkg::RATE_W-1:0] turn_decel_rate,
	input wire logic [drive_sup_pkg::PCT_W-1:0] min_decel_pct,
	input wire logic [drive_sup_pkg::PCT_W-1:0] min_turn_accel_pct,
	input wire logic [drive_sup_pkg::PCT_W-1:0] min_turn_decel_pct,
	input wire logic [drive_sup_pkg::RATE_W-1:0] fast_brake_rate,
	input wire logic [drive_sup_pkg::RATE_W-1:0] soft_stop_rate,
	input wire logic [drive_sup_pkg::PCT_W-1:0] soft_rev_pct,
	// Operation parameters.
	input wire logic [4:0] sleep_minutes,
	input wire logic invert_joystick,
	input wire logic signed [4:0] steer_trim,
	input wire logic [3:0] beep_volume,
	input wire logic adjust_while_driving,
	input wire logic service_due,
	input wire logic [2:0] lowbat_code,
	input wire logic [7:0] cutout_threshold,
	input wire logic [7:0] low_volt_seconds,
	input wire logic reverse_alarm_en,
	input wire logic brake_alarm_en,
	input wire logic brake_fault_en,
	input wire logic [5:0] stationary_minutes,
	input wire logic [drive_sup_pkg::AXIS_W-1:0] stationary_window,
	// Pins from the chair.
	input wire logic signed [drive_sup_pkg::AXIS_W-1:0] joy_fwd,
	input wire logic signed [drive_sup_pkg::AXIS_W-1:0] joy_turn,
	input wire logic btn_up,
	input wire logic btn_down,
	input wire logic power_switch,
	input wire logic [7:0] battery_level,
	input wire logic at_rest,
	input wire logic brake_disconnected,
	input wire logic brake_fault_sense,
	// Drive outputs.
	output logic signed [drive_sup_pkg::DEM_W-1:0] left_demand,
	output logic signed [drive_sup_pkg::DEM_W-1:0] right_demand,
	output logic [drive_sup_pkg::RATE_W-1:0] active_decel,
	output logic [drive_sup_pkg::RATE_W-1:0] turn_accel_out,
	output logic [drive_sup_pkg::RATE_W-1:0] turn_decel_out,
	output logic [2:0] speed_setting,
	output logic drive_cut,
	// Status and annunciation.
	output logic sleep_active,
	output logic low_volt_cutout,
	output logic brake_fault,
	output logic [drive_sup_pkg::LED_COUNT-1:0] gauge_leds,
	output logic alarm,
	output logic [3:0] beep_level
);
	import drive_sup_pkg::*;

	// ************************************************************
	// Pin synchronisers.
	// ************************************************************
	localparam int SYN_W = 2 * AXIS_W + 8 + 6;
	logic [SYN_W-1:0] s1_q, s2_q;
	always_ff @(posedge clk) begin
		if (reset) begin
			s1_q <= '0;
			s2_q <= '0;
		end else if (ce) begin
			s1_q <= {joy_fwd, joy_turn, battery_level, btn_up, btn_down, power_switch,
				at_rest, brake_disconnected, brake_fault_sense};
			s2_q <= s1_q;
		end
	end
	logic signed [AXIS_W-1:0] jf, jt;
	logic [7:0] batt;
	logic b_up, b_dn, pwr, rest, brk_disc, brk_sense;
	assign {jf, jt, batt, b_up, b_dn, pwr, rest, brk_disc, brk_sense} = s2_q;

	function automatic logic [AXIS_W-1:0] mag(input logic signed [AXIS_W-1:0] v);
		return v[AXIS_W-1] ? AXIS_W'(-v) : AXIS_W'(v);
	endfunction

	// ************************************************************
	// Ramp scaling.
	// ************************************************************
	logic [2:0] speed_q, speed_d;
	logic [RATE_W-1:0] dec_scaled;
	ramp_scale #(.W(RATE_W)) u_dec (.clk(clk), .reset(reset), .ce(ce),
		.full_rate(decel_rate), .min_pct(min_decel_pct), .speed_set(speed_q),
		.rate(dec_scaled));
	ramp_scale #(.W(RATE_W)) u_tacc (.clk(clk), .reset(reset), .ce(ce),
		.full_rate(turn_accel_rate), .min_pct(min_turn_accel_pct), .speed_set(speed_q),
		.rate(turn_accel_out));
	ramp_scale #(.W(RATE_W)) u_tdec (.clk(clk), .reset(reset), .ce(ce),
		.full_rate(turn_decel_rate), .min_pct(min_turn_decel_pct), .speed_set(speed_q),
		.rate(turn_decel_out));

	// ************************************************************
	// Prescaler: millisecond, second and minute ticks.
	// ************************************************************
	logic [31:0] pre_q, pre_d;
	logic [9:0] ms_q, ms_d;
	logic [5:0] sec_q, sec_d;
	logic tick_ms, tick_s, tick_m;
	always_comb begin
		tick_ms = (pre_q == 32'(TICK_DIV - 1));
		tick_s = tick_ms && (ms_q == 10'(MS_PER_SEC - 1));
		tick_m = tick_s && (sec_q == 6'(SEC_PER_MIN - 1));
		pre_d = tick_ms ? '0 : pre_q + 32'h1;
		ms_d = tick_s ? '0 : (tick_ms ? ms_q + 10'h1 : ms_q);
		sec_d = tick_m ? '0 : (tick_s ? sec_q + 6'h1 : sec_q);
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			pre_q <= '0;
			ms_q <= '0;
			sec_q <= '0;
		end else if (ce) begin
			pre_q <= pre_d;
			ms_q <= ms_d;
			sec_q <= sec_d;
		end
	end

	// ************************************************************
	// Speed buttons and beep.
	// ************************************************************
	logic up_q, dn_q, up_d, dn_d;
	logic [3:0] beep_q, beep_d, beep_t_q, beep_t_d;
	logic driving, press, allow;
	always_comb begin
		driving = (jf != '0) || (jt != '0);
		up_d = b_up;
		dn_d = b_dn;
		press = (b_up && !up_q) || (b_dn && !dn_q);
		allow = adjust_while_driving || (!driving && rest);
		speed_d = speed_q;
		if (allow && b_up && !up_q && speed_q < SPEED_MAX) begin
			speed_d = speed_q + 3'h1;
		end else if (allow && b_dn && !dn_q && speed_q > SPEED_MIN) begin
			speed_d = speed_q - 3'h1;
		end
		beep_t_d = beep_t_q;
		beep_d = beep_q;
		if (press && beep_volume != 4'h0) begin
			beep_t_d = BEEP_LEN_MS;
			beep_d = (beep_volume > BEEP_MAX) ? BEEP_MAX : beep_volume;
		end else if (beep_t_q != 4'h0) begin
			beep_t_d = tick_ms ? beep_t_q - 4'h1 : beep_t_q;
		end else begin
			beep_d = 4'h0;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			speed_q <= SPEED_MIN;
			up_q <= 1'b0;
			dn_q <= 1'b0;
			beep_q <= 4'h0;
			beep_t_q <= 4'h0;
		end else if (ce) begin
			speed_q <= speed_d;
			up_q <= up_d;
			dn_q <= dn_d;
			beep_q <= beep_d;
			beep_t_q <= beep_t_d;
		end
	end

	// ************************************************************
	// Sleep, stationary and low voltage timers.
	// ************************************************************
	logic [4:0] idle_q, idle_d;
	logic [5:0] stat_q, stat_d;
	logic [8:0] lv_q, lv_d;
	logic sleep_q, sleep_d, cut_q, cut_d, lvc_q, lvc_d;
	logic signed [AXIS_W-1:0] ref_f_q, ref_t_q, ref_f_d, ref_t_d;
	logic moved;
	always_comb begin
		moved = (mag(AXIS_W'(jf - ref_f_q)) > stationary_window) ||
			(mag(AXIS_W'(jt - ref_t_q)) > stationary_window);
		// Minute and second ticks run free, so each timer counts one tick past its
		// setting: the wait is never shorter than programmed, at most one tick longer.
		idle_d = driving ? '0 : (tick_m && idle_q <= SLEEP_MAX_MIN ? idle_q + 5'h1 : idle_q);
		sleep_d = (sleep_minutes != 5'h0) && (idle_d > sleep_minutes);
		ref_f_d = ref_f_q;
		ref_t_d = ref_t_q;
		stat_d = stat_q;
		if (!driving || moved) begin
			stat_d = '0;
			ref_f_d = jf;
			ref_t_d = jt;
		end else if (tick_m && stat_q <= STAT_MAX_MIN) begin
			stat_d = stat_q + 6'h1;
		end
		cut_d = (stationary_minutes != 6'h0) && driving &&
			(stat_d > stationary_minutes);
		lv_d = (batt > cutout_threshold) ? '0 :
			(tick_s && lv_q != 9'h1FF ? lv_q + 9'h1 : lv_q);
		// The cut out latches; only reset brings the chair back.
		lvc_d = lvc_q || (lv_d > 9'(low_volt_seconds) && low_volt_seconds != 8'h0);
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			idle_q <= '0;
			stat_q <= '0;
			lv_q <= '0;
			sleep_q <= 1'b0;
			cut_q <= 1'b0;
			lvc_q <= 1'b0;
			ref_f_q <= '0;
			ref_t_q <= '0;
		end else if (ce) begin
			idle_q <= idle_d;
			stat_q <= stat_d;
			lv_q <= lv_d;
			sleep_q <= sleep_d;
			cut_q <= cut_d;
			lvc_q <= lvc_d;
			ref_f_q <= ref_f_d;
			ref_t_q <= ref_t_d;
		end
	end

	// ************************************************************
	// Demand shaping and braking rate selection.
	// ************************************************************
	logic signed [DEM_W-1:0] left_q, left_d, right_q, right_d, fwd_e, turn_e, trim_e;
	logic [RATE_W-1:0] dec_q, dec_d;
	logic [RATE_W+PCT_W-1:0] rev_w;
	logic rev_q, rev_d, halt;
	logic was_rest_q, was_rest_d;
	always_comb begin
		fwd_e = invert_joystick ? -DEM_W'(jf) : DEM_W'(jf);
		trim_e = (steer_trim > TRIM_MAX) ? DEM_W'(TRIM_MAX) :
			((steer_trim < TRIM_MIN) ? DEM_W'(TRIM_MIN) : DEM_W'(steer_trim));
		turn_e = DEM_W'(jt);
		halt = cut_q || lvc_q || sleep_q || !pwr;
		left_d = halt ? '0 : fwd_e + turn_e + ((fwd_e != '0) ? trim_e : '0);
		right_d = halt ? '0 : fwd_e - turn_e - ((fwd_e != '0) ? trim_e : '0);
		// The pins carry no speed sign, so direction is fixed as the chair leaves rest.
		was_rest_d = rest;
		rev_d = rest ? 1'b0 : (was_rest_q ? (fwd_e < 0) : rev_q);
		rev_w = (RATE_W+PCT_W)'(dec_scaled) * (RATE_W+PCT_W)'(soft_rev_pct);
		if (!pwr && !rest) begin
			dec_d = soft_stop_rate;
		end else if (!rev_q && fwd_e < 0) begin
			// Pulling back while moving forward is a fast brake.
			dec_d = (fast_brake_rate < dec_scaled) ? dec_scaled : fast_brake_rate;
		end else if (rev_q && fwd_e == '0) begin
			dec_d = RATE_W'(rev_w / (RATE_W+PCT_W)'(PCT_FULL));
		end else begin
			dec_d = dec_scaled;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			left_q <= '0;
			right_q <= '0;
			dec_q <= '0;
			rev_q <= 1'b0;
			was_rest_q <= 1'b1;
		end else if (ce) begin
			left_q <= left_d;
			right_q <= right_d;
			dec_q <= dec_d;
			rev_q <= rev_d;
			was_rest_q <= was_rest_d;
		end
	end

	// ************************************************************
	// Battery gauge, service reminder and alarms.
	// ************************************************************
	logic [10:0] svc_ms_q, svc_ms_d;
	logic [4:0] svc_s_q, svc_s_d;
	logic [LED_COUNT-1:0] leds_q, leds_d;
	logic alarm_q, alarm_d, bf_q, bf_d, svc_win;
	always_comb begin
		svc_win = service_due && (svc_s_q < 5'(SERVICE_WINDOW_SEC));
		svc_ms_d = !tick_ms ? svc_ms_q :
			((svc_ms_q == 11'(SERVICE_PERIOD_MS - 1)) ? '0 : svc_ms_q + 11'h1);
		svc_s_d = (tick_s && svc_s_q != 5'h1F) ? svc_s_q + 5'h1 : svc_s_q;
		leds_d = '0;
		if (svc_win) begin
			leds_d = (svc_ms_q < 11'(SERVICE_ON_MS)) ? '1 : '0;
		end else begin
			unique case (lowbat_code)
				LOWBAT_OFF: leds_d = '0;
				LOWBAT_FLASH: leds_d = {4'h0, sec_q[0]};
				LOWBAT_STEADY: leds_d = 5'h01;
				3'h3: leds_d = 5'h03;
				3'h4: leds_d = 5'h07;
				3'h5: leds_d = 5'h0F;
				default: leds_d = '0;
			endcase
		end
		bf_d = brake_fault_en && brk_sense;
		alarm_d = (lowbat_code != LOWBAT_OFF && lowbat_code <= LOWBAT_MAX) ||
			(reverse_alarm_en && rev_q && !rest) ||
			(brake_alarm_en && brk_disc);
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			svc_ms_q <= '0;
			svc_s_q <= '0;
			leds_q <= '0;
			alarm_q <= 1'b0;
			bf_q <= 1'b0;
		end else if (ce) begin
			svc_ms_q <= svc_ms_d;
			svc_s_q <= svc_s_d;
			leds_q <= leds_d;
			alarm_q <= alarm_d;
			bf_q <= bf_d;
		end
	end

	assign left_demand = left_q;
	assign right_demand = right_q;
	assign active_decel = dec_q;
	assign speed_setting = speed_q;
	assign drive_cut = cut_q;
	assign sleep_active = sleep_q;
	assign low_volt_cutout = lvc_q;
	assign brake_fault = bf_q;
	assign gauge_leds = leds_q;
	assign alarm = alarm_q;
	assign beep_level = beep_q;
endmodule

/* hw/drive_sup_pkg.sv */
/*
 Shared constants for the drive parameter supervisor: widths, field limits,
 speed settings, low battery codes and timing counts.
 Assumes a 100 MHz system clock.
*/
package drive_sup_pkg;

	// ************************************************************
	// Clock and time base.
	// ************************************************************
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int MS_PER_SEC = 1000;
	localparam int SEC_PER_MIN = 60;
	localparam int SERVICE_ON_MS = 100;
	localparam int SERVICE_PERIOD_MS = 1100;
	localparam int SERVICE_WINDOW_SEC = 20;

	// ************************************************************
	// Field widths and limits.
	// ************************************************************
	localparam int RATE_W = 8;
	localparam int PCT_W = 7;
	localparam int AXIS_W = 8;
	localparam int DEM_W = 10;
	localparam logic [2:0] SPEED_MIN = 3'h1;
	localparam logic [2:0] SPEED_MAX = 3'h5;
	localparam logic [2:0] SPEED_STEPS = 3'h4;
	localparam logic [6:0] PCT_FULL = 7'h64;
	localparam logic [4:0] SLEEP_MAX_MIN = 5'h1E;
	localparam logic [5:0] STAT_MAX_MIN = 6'h3C;
	localparam logic signed [4:0] TRIM_MIN = -5'sd9;
	localparam logic signed [4:0] TRIM_MAX = 5'sd9;
	localparam logic [3:0] BEEP_MAX = 4'hA;
	localparam logic [3:0] BEEP_LEN_MS = 4'h5;

	// ************************************************************
	// Low battery display codes and LED count.
	// ************************************************************
	localparam logic [2:0] LOWBAT_OFF = 3'h0;
	localparam logic [2:0] LOWBAT_FLASH = 3'h1;
	localparam logic [2:0] LOWBAT_STEADY = 3'h2;
	localparam logic [2:0] LOWBAT_MAX = 3'h5;
	localparam int LED_COUNT = 5;

endpackage

/* hw/ramp_scale.sv */
/*
 Scales one ramp rate across the five speed settings.
 Assumes inputs are stable levels from the same clock domain.
*/
module ramp_scale
	import drive_sup_pkg::*;
#(
	parameter int W = RATE_W
) (
	// Clock.
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Parameters.
	input wire logic [W-1:0] full_rate,
	input wire logic [PCT_W-1:0] min_pct,
	input wire logic [2:0] speed_set,
	// Result.
	output logic [W-1:0] rate
);
	logic [W-1:0] rate_q, rate_d;
	logic [W+PCT_W:0] low_w;
	logic [W+3:0] span_w;
	logic [W-1:0] low_rate;

	always_comb begin
		low_w = (W+PCT_W+1)'(full_rate) * (W+PCT_W+1)'(min_pct);
		low_rate = W'(low_w / (W+PCT_W+1)'(PCT_FULL));
		span_w = (W+4)'(full_rate - low_rate) * (W+4)'(speed_set - SPEED_MIN);
		if (speed_set >= SPEED_MAX) begin
			rate_d = full_rate;
		end else if (speed_set <= SPEED_MIN) begin
			rate_d = low_rate;
		end else begin
			rate_d = low_rate + W'(span_w / (W+4)'(SPEED_STEPS));
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rate_q <= '0;
		end else if (ce) begin
			rate_q <= rate_d;
		end
	end

	assign rate = rate_q;
endmodule

/* verif/chair_model.sv */
/*
 Behavioural model of the chair around the supervisor: joystick, speed
 buttons, power switch, battery and brakes.
 Assumes the bench calls its tasks just after a falling clock edge.
*/
module chair_model
	import drive_sup_pkg::*;
(
	// Clock.
	input wire logic clk,
	// Pins toward the supervisor.
	output logic signed [drive_sup_pkg::AXIS_W-1:0] joy_fwd,
	output logic signed [drive_sup_pkg::AXIS_W-1:0] joy_turn,
	output logic btn_up,
	output logic btn_down,
	output logic power_switch,
	output logic [7:0] battery_level,
	output logic at_rest,
	output logic brake_disconnected,
	output logic brake_fault_sense
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// Pin drivers.
	// ************************************************************
	initial begin
		joy_fwd = 8'h00;
		joy_turn = 8'h00;
		btn_up = 1'b0;
		btn_down = 1'b0;
		power_switch = 1'b1;
		battery_level = 8'hC0;
		at_rest = 1'b1;
		brake_disconnected = 1'b0;
		brake_fault_sense = 1'b0;
	end

	// The chair is taken to be moving whenever the stick is off centre.
	task automatic set_joy(input logic signed [7:0] f, input logic signed [7:0] t);
		joy_fwd = f;
		joy_turn = t;
		at_rest = (f == 8'sh00) && (t == 8'sh00);
	endtask

	// Held four edges, longer than the pin synchroniser, then released as long.
	task automatic press(input logic up);
		btn_up = up;
		btn_down = !up;
		repeat (4) @(negedge clk);
		btn_up = 1'b0;
		btn_down = 1'b0;
		repeat (4) @(negedge clk);
	endtask
endmodule

/* verif/drive_sup_chk.sv */
/*
 Checker for the drive parameter supervisor: timing relations at its ports.
 Assumes binding to the top module and a single clock with synchronous reset.
*/
module drive_sup_chk
	import drive_sup_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Watched inputs.
	input wire logic [drive_sup_pkg::RATE_W-1:0] turn_accel_rate,
	input wire logic [drive_sup_pkg::RATE_W-1:0] turn_decel_rate,
	input wire logic [drive_sup_pkg::PCT_W-1:0] min_turn_decel_pct,
	input wire logic [2:0] lowbat_code,
	input wire logic brake_fault_en,
	input wire logic brake_fault_sense,
	// Watched outputs.
	input wire logic [drive_sup_pkg::RATE_W-1:0] turn_accel_out,
	input wire logic [drive_sup_pkg::RATE_W-1:0] turn_decel_out,
	input wire logic [2:0] speed_setting,
	input wire logic low_volt_cutout,
	input wire logic brake_fault,
	input wire logic alarm
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// Port relations.
	// ************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_speed_in_range: assert property (speed_setting >= SPEED_MIN && speed_setting <= SPEED_MAX)
		else $error("speed setting out of range");
	// The reset edge itself is excluded, so a one-edge reset cannot look like a jump.
	a_speed_one_step: assert property (!$past(reset) && $changed(speed_setting) |->
		speed_setting == $past(speed_setting) + 3'h1 || speed_setting == $past(speed_setting) - 3'h1)
		else $error("speed setting moved by more than one step");
	a_full_rate_top: assert property ((ce && speed_setting == SPEED_MAX &&
		$stable(turn_accel_rate))[*3] |-> turn_accel_out == turn_accel_rate)
		else $error("top setting does not give the full turn acceleration");
	a_low_rate_bottom: assert property ((ce && speed_setting == SPEED_MIN &&
		$stable(turn_decel_rate) && $stable(min_turn_decel_pct))[*3] |->
		turn_decel_out == 8'((16'(turn_decel_rate) * 16'(min_turn_decel_pct)) / 16'h64))
		else $error("lowest setting turn deceleration wrong");
	a_fault_follows: assert property ((ce && brake_fault_en && brake_fault_sense)[*4] |=> brake_fault)
		else $error("brake fault not reported");
	a_fault_gated: assert property ((ce && !brake_fault_en)[*2] |=> !brake_fault)
		else $error("brake fault reported while detection is off");
	a_lowbat_alarm: assert property ((ce && lowbat_code != LOWBAT_OFF &&
		lowbat_code <= LOWBAT_MAX)[*2] |=> alarm)
		else $error("low battery code without alarm");
	a_cutout_holds: assert property (low_volt_cutout |=> low_volt_cutout)
		else $error("low voltage cut out released without reset");

	c_top_speed: cover property (speed_setting == SPEED_MAX);
	c_cutout: cover property ($rose(low_volt_cutout));
	c_brake_fault: cover property ($rose(brake_fault));
endmodule

bind drive_parameter_supervisor drive_sup_chk chk (.*);

/* verif/tb_drive_parameter_supervisor.sv */
/*
 Self-checking bench for the drive parameter supervisor.
 Assumes a shortened prescaler of 10 cycles per millisecond.
*/
module tb_drive_parameter_supervisor
	import drive_sup_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// Stimulus, model and device.
	// ************************************************************
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [7:0] decel_rate = 8'h50, turn_accel_rate = 8'h50, turn_decel_rate = 8'h50;
	logic [6:0] min_decel_pct = 7'h19, min_turn_accel_pct = 7'h32, min_turn_decel_pct = 7'h0A;
	logic [7:0] fast_brake_rate = 8'h28, soft_stop_rate = 8'h5A;
	logic [6:0] soft_rev_pct = 7'h46;
	logic [4:0] sleep_minutes = 5'h00;
	logic signed [4:0] steer_trim = 5'sh00;
	logic [3:0] beep_volume = 4'h7;
	logic [2:0] lowbat_code = 3'h0;
	logic [7:0] cutout_threshold = 8'h80, low_volt_seconds = 8'h02, stationary_window = 8'h10;
	logic [5:0] stationary_minutes = 6'h00;
	logic invert_joystick = 1'b0, adjust_while_driving = 1'b1, service_due = 1'b1;
	logic reverse_alarm_en = 1'b0, brake_alarm_en = 1'b0, brake_fault_en = 1'b0;
	logic signed [7:0] joy_fwd, joy_turn;
	logic btn_up, btn_down, power_switch, at_rest, brake_disconnected, brake_fault_sense;
	logic [7:0] battery_level, active_decel, turn_accel_out, turn_decel_out;
	logic signed [9:0] left_demand, right_demand;
	logic [2:0] speed_setting;
	logic drive_cut, sleep_active, low_volt_cutout, brake_fault, alarm;
	logic [4:0] gauge_leds;
	logic [3:0] beep_level;
	int mismatches = 0;
	int comparisons = 0;

	chair_model m (.*);
	drive_parameter_supervisor #(.TICK_DIV(10)) dut (.*);

	always #5 clk = ~clk;

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask

	function automatic logic [15:0] ramp(input logic [7:0] full, input logic [6:0] pct, input int n);
		int lo;
		lo = full * pct / 100;
		return 16'(lo + (full - lo) * (n - 1) / 4);
	endfunction

	task automatic check_rates(input int n);
		check("speed", 16'(n), {13'h0, speed_setting});
		check("decel", ramp(decel_rate, min_decel_pct, n), {8'h0, active_decel});
		check("t_acc", ramp(turn_accel_rate, min_turn_accel_pct, n), {8'h0, turn_accel_out});
		check("t_dec", ramp(turn_decel_rate, min_turn_decel_pct, n), {8'h0, turn_decel_out});
	endtask

	task automatic press_beep(input logic up, input logic [3:0] vol, input logic [15:0] exp);
		beep_volume = vol;
		step(60);
		m.press(up);
		check("beep", exp, {12'h0, beep_level});
	endtask

	task automatic wrap_up();
		if (mismatches == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		wrap_up();
	end

	initial begin
		step(5);
		reset = 1'b0;
		step(500);
		check("svc_on", 16'h1F, {11'h0, gauge_leds});
		step(1000);
		check("svc_off", 16'h00, {11'h0, gauge_leds});
		service_due = 1'b0;
		check_rates(1);
		for (int n = 2; n <= 6; n++) begin
			m.press(1'b1);
			check_rates(n > 5 ? 5 : n);
		end
		check("beep", 16'h7, {12'h0, beep_level});
		press_beep(1'b0, 4'hC, 16'h000A);
		press_beep(1'b0, 4'h0, 16'h0000);
		adjust_while_driving = 1'b0;
		m.set_joy(8'sh28, 8'sh00);
		m.press(1'b0);
		check("refused", 16'h3, {13'h0, speed_setting});
		m.set_joy(8'sh00, 8'sh00);
		m.press(1'b0);
		check("at_rest", 16'h2, {13'h0, speed_setting});
		adjust_while_driving = 1'b1;
		m.set_joy(8'sh28, 8'sh00);
		m.press(1'b1);
		check("driving", 16'h3, {13'h0, speed_setting});
		step(5);
		check("fwd", 16'h1, {15'h0, left_demand > 0 && right_demand > 0});
		invert_joystick = 1'b1;
		step(5);
		check("inverted", 16'h1, {15'h0, left_demand < 0 && right_demand < 0});
		invert_joystick = 1'b0;
		steer_trim = 5'sh03;
		step(5);
		check("trim_pos", 16'h0006, 16'(left_demand - right_demand));
		steer_trim = 5'sh17;
		step(5);
		check("trim_neg", 16'hFFEE, 16'(left_demand - right_demand));
		steer_trim = 5'sh00;
		m.power_switch = 1'b0;
		step(5);
		check("soft_stop", 16'(soft_stop_rate), {8'h0, active_decel});
		m.power_switch = 1'b1;
		m.set_joy(8'sh00, 8'sh00);
		for (int c = 0; c <= 5; c++) begin
			lowbat_code = 3'(c);
			step(5);
			check("lowbat_alarm", 16'(c != 0), {15'h0, alarm});
			if (c >= 2) check("lowbat_leds", 16'((1 << (c - 1)) - 1), {11'h0, gauge_leds});
		end
		lowbat_code = LOWBAT_OFF;
		brake_fault_en = 1'b1;
		m.brake_fault_sense = 1'b1;
		step(5);
		check("brake_fault", 16'h1, {15'h0, brake_fault});
		brake_fault_en = 1'b0;
		step(5);
		check("brake_fault_off", 16'h0, {15'h0, brake_fault});
		brake_alarm_en = 1'b1;
		m.brake_disconnected = 1'b1;
		step(5);
		check("brake_alarm", 16'h1, {15'h0, alarm});
		m.brake_disconnected = 1'b0;
		step(5);
		check("brake_alarm_off", 16'h0, {15'h0, alarm});
		// Speed setting is 3 here; pulling back while moving forward is a fast brake.
		reverse_alarm_en = 1'b1;
		m.set_joy(8'sh28, 8'sh00);
		step(5);
		m.set_joy(8'shD8, 8'sh00);
		step(5);
		check("fast_brake_low", ramp(decel_rate, min_decel_pct, 3), {8'h0, active_decel});
		check("rev_alarm_fwd", 16'h0, {15'h0, alarm});
		fast_brake_rate = 8'hC8;
		step(5);
		check("fast_brake_high", 16'h00C8, {8'h0, active_decel});
		m.set_joy(8'sh00, 8'sh00);
		step(5);
		m.set_joy(8'shD8, 8'sh00);
		step(5);
		check("rev_alarm", 16'h1, {15'h0, alarm});
		m.joy_fwd = 8'sh00;
		step(5);
		check("soft_rev", 16'(ramp(decel_rate, min_decel_pct, 3) * soft_rev_pct / 100),
			{8'h0, active_decel});
		m.set_joy(8'sh00, 8'sh00);
		step(5);
		check("rev_alarm_off", 16'h0, {15'h0, alarm});
		m.battery_level = cutout_threshold;
		step(5000);
		m.battery_level = 8'hC0;
		step(10);
		m.battery_level = cutout_threshold;
		step(19000);
		check("cutout_early", 16'h0, {15'h0, low_volt_cutout});
		step(13000);
		check("cutout", 16'h1, {15'h0, low_volt_cutout});
		m.battery_level = 8'hC0;
		step(10);
		check("cutout_held", 16'h1, {15'h0, low_volt_cutout});
		check("no_sleep", 16'h0, {15'h0, sleep_active});
		check("no_cut", 16'h0, {15'h0, drive_cut});
		wrap_up();
	end
endmodule
